/* rtl/argo_pkg.sv */
// constants for the reset, gain and offset register group
// assumes an 8-bit register port with a 12-bit address from the config port
// How it works
// - a zero-to-one edge on the soft reset bit resets all digital logic
// - soft reset bit never self-clears; host writes zero then one
// - gain code bits 14..8 in high register bits 6..0, 7..0 in low
// - gain high resets to 0x40 and low to zero, code 0x4000
// - offset code bits 14..8 in high register, 7..0 in low register
// - one offset code drives every interleaved sampling bank alike
// - offset code 0x0000 is -28 mV, 0x4000 zero, 0x7FFF +28 mV
// - offset adjustment ignored while background calibration is on
// - bit 7 of both high registers is reserved, read-write, resets zero
package argo_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int CODE_W = 15;
  localparam logic [11:0] OFF_RSVD_A   = 12'h020;
  localparam logic [11:0] OFF_SOFT_RST = 12'h021;
  localparam logic [11:0] OFF_GAIN_HI  = 12'h022;
  localparam logic [11:0] OFF_GAIN_LO  = 12'h023;
  localparam logic [11:0] OFF_RSVD_B   = 12'h024;
  localparam logic [11:0] OFF_OFFS_HI  = 12'h025;
  localparam logic [11:0] OFF_OFFS_LO  = 12'h026;
  localparam logic [11:0] OFF_RSVD_C   = 12'h027;
  localparam logic [11:0] OFF_RSVD_D   = 12'h028;
  localparam logic [11:0] OFF_RSVD_E   = 12'h029;
  localparam logic [11:0] OFF_RSVD_F   = 12'h02A;
  localparam logic [7:0] RST_RSVD_A   = 8'h9D;
  localparam logic [7:0] RST_SOFT_RST = 8'h00;
  localparam logic [7:0] RST_GAIN_HI  = 8'h40;
  localparam logic [7:0] RST_GAIN_LO  = 8'h00;
  localparam logic [7:0] RST_RSVD_B   = 8'h00;
  localparam logic [7:0] RST_OFFS_HI  = 8'h40;
  localparam logic [7:0] RST_OFFS_LO  = 8'h00;
  localparam logic [7:0] RST_RSVD_C   = 8'h06;
  localparam logic [7:0] RST_RSVD_D   = 8'hBA;
  localparam logic [7:0] RST_RSVD_E   = 8'hD4;
  localparam logic [7:0] RST_RSVD_F   = 8'hAA;
  localparam int SOFT_RST_BIT = 0;
  localparam int HI_CODE_MSB  = 6;
  localparam int RSVD_HI_BIT  = 7;
  localparam logic [14:0] OFFS_ZERO_CODE = 15'h4000;
  localparam int OFFS_FS_UV   = 28000;
  // reset pulse length in ns, rounded up to whole mclk cycles
  localparam int SRST_TIME_NS = 80;
  localparam int CLK_NS       = 40;
  localparam int SRST_CYC     = (SRST_TIME_NS + CLK_NS - 1) / CLK_NS;
endpackage

/* rtl/argo_srst.sv */
// soft reset edge detector and pulse stretcher
// assumes soft reset bit comes from a register on mclk
`timescale 1ns/1ps
module argo_srst #(
  parameter int PULSE_CYC = argo_pkg::SRST_CYC
) (
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic srst_bit,
  output logic      dig_reset
);
  // refuse pulse lengths that the 8-bit counter cannot hold
  if (PULSE_CYC < 1 || PULSE_CYC > 255) begin : g_bad_pulse
    $error("argo_srst: PULSE_CYC out of range");
  end
  typedef struct packed {
    logic       prev;
    logic [7:0] cnt;
  } argo_srst_s;
  argo_srst_s st_reg;
  argo_srst_s st_next;
  always_comb begin
    st_next = st_reg;
    st_next.prev = srst_bit;
    if (srst_bit && !st_reg.prev) begin
      st_next.cnt = 8'(PULSE_CYC);
    end else if (st_reg.cnt != 8'h00) begin
      st_next.cnt = st_reg.cnt - 8'h01;
    end
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign dig_reset = (st_reg.cnt != 8'h00);
endmodule

/* rtl/argo_offs_map.sv */
// maps the offset code to a signed offset in microvolts
// assumes code and calibration flag are registered on mclk
`timescale 1ns/1ps
module argo_offs_map (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic [14:0] code,
  input  wire logic        bg_cal_en,
  output logic signed [15:0] offset_uv
);
  typedef struct packed {
    logic signed [15:0] uv;
  } argo_offs_s;
  argo_offs_s st_reg;
  argo_offs_s st_next;
  logic signed [31:0] delta;
  logic signed [31:0] scaled;
  always_comb begin
    st_next = st_reg;
    delta   = 32'(signed'({1'b0, code})) -
              32'(signed'({1'b0, argo_pkg::OFFS_ZERO_CODE}));
    // linear: 16384 steps per side; 0x7FFF lands one step short of full
    scaled  = (delta * argo_pkg::OFFS_FS_UV) >>> 14;
    if (bg_cal_en) begin
      st_next.uv = 16'sh0000;
    end else begin
      st_next.uv = scaled[15:0];
    end
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign offset_uv = st_reg.uv;
endmodule

/* rtl/argo_regs.sv */
// reset, gain and offset register group of the converter
// assumes the config port decoder hands single-cycle byte writes and reads
// with a 12-bit address; read data is registered and appears one cycle later
`timescale 1ns/1ps
module argo_regs #(
  parameter int NUM_BANKS = 4,
  parameter int SRST_PULSE = argo_pkg::SRST_CYC
) (
  input  wire logic                   mclk,
  input  wire logic                   reset,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  input  wire logic [11:0]            reg_addr,
  input  wire logic [7:0]             reg_wdata,
  output logic      [7:0]             reg_rdata,
  output logic                        reg_hit,
  input  wire logic                   bg_cal_en,
  output logic                        digital_soft_reset,
  output logic                        dig_reset,
  output logic      [14:0]            full_scale_gain_code,
  output logic      [14:0]            converter_offset_code,
  output logic signed [16*NUM_BANKS-1:0] bank_offset_uv
);
  if (NUM_BANKS < 1 || NUM_BANKS > 16) begin : g_bad_banks
    $error("argo_regs: NUM_BANKS out of range");
  end

  typedef struct packed {
    logic [7:0] rsvd_a;
    logic [7:0] soft_rst;
    logic [7:0] gain_hi;
    logic [7:0] gain_lo;
    logic [7:0] rsvd_b;
    logic [7:0] offs_hi;
    logic [7:0] offs_lo;
    logic [7:0] rsvd_c;
    logic [7:0] rsvd_d;
    logic [7:0] rsvd_e;
    logic [7:0] rsvd_f;
    logic [7:0] rdata;
    logic       cal_s1;
    logic       cal_s2;
  } argo_regs_s;

  argo_regs_s st_reg;
  argo_regs_s st_next;
  logic       any_reset;
  logic       hit;
  logic [7:0] rd_mux;
  logic signed [15:0] offs_uv;

  // a soft reset clears the digital logic, but the soft reset register
  // itself keeps its value: it does not self-clear
  assign any_reset = reset | dig_reset;

  always_comb begin
    hit    = 1'b1;
    rd_mux = 8'h00;
    unique case (reg_addr)
      argo_pkg::OFF_RSVD_A:   rd_mux = st_reg.rsvd_a;
      argo_pkg::OFF_SOFT_RST: rd_mux = st_reg.soft_rst;
      argo_pkg::OFF_GAIN_HI:  rd_mux = st_reg.gain_hi;
      argo_pkg::OFF_GAIN_LO:  rd_mux = st_reg.gain_lo;
      argo_pkg::OFF_RSVD_B:   rd_mux = st_reg.rsvd_b;
      argo_pkg::OFF_OFFS_HI:  rd_mux = st_reg.offs_hi;
      argo_pkg::OFF_OFFS_LO:  rd_mux = st_reg.offs_lo;
      argo_pkg::OFF_RSVD_C:   rd_mux = st_reg.rsvd_c;
      argo_pkg::OFF_RSVD_D:   rd_mux = st_reg.rsvd_d;
      argo_pkg::OFF_RSVD_E:   rd_mux = st_reg.rsvd_e;
      argo_pkg::OFF_RSVD_F:   rd_mux = st_reg.rsvd_f;
      default:                hit = 1'b0;
    endcase
  end

  always_comb begin
    st_next        = st_reg;
    st_next.cal_s1 = bg_cal_en;
    st_next.cal_s2 = st_reg.cal_s1;
    st_next.rdata  = reg_rd ? rd_mux : st_reg.rdata;
    if (reg_wr) begin
      unique case (reg_addr)
        argo_pkg::OFF_SOFT_RST: st_next.soft_rst = reg_wdata;
        argo_pkg::OFF_GAIN_HI:  st_next.gain_hi  = reg_wdata;
        argo_pkg::OFF_GAIN_LO:  st_next.gain_lo  = reg_wdata;
        argo_pkg::OFF_OFFS_HI:  st_next.offs_hi  = reg_wdata;
        argo_pkg::OFF_OFFS_LO:  st_next.offs_lo  = reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (any_reset) begin
      st_reg.rsvd_a  <= argo_pkg::RST_RSVD_A;
      st_reg.gain_hi <= argo_pkg::RST_GAIN_HI;
      st_reg.gain_lo <= argo_pkg::RST_GAIN_LO;
      st_reg.rsvd_b  <= argo_pkg::RST_RSVD_B;
      st_reg.offs_hi <= argo_pkg::RST_OFFS_HI;
      st_reg.offs_lo <= argo_pkg::RST_OFFS_LO;
      st_reg.rsvd_c  <= argo_pkg::RST_RSVD_C;
      st_reg.rsvd_d  <= argo_pkg::RST_RSVD_D;
      st_reg.rsvd_e  <= argo_pkg::RST_RSVD_E;
      st_reg.rsvd_f  <= argo_pkg::RST_RSVD_F;
      st_reg.rdata   <= 8'h00;
      st_reg.cal_s1  <= 1'b0;
      st_reg.cal_s2  <= 1'b0;
    end else begin
      st_reg.rsvd_a  <= st_next.rsvd_a;
      st_reg.gain_hi <= st_next.gain_hi;
      st_reg.gain_lo <= st_next.gain_lo;
      st_reg.rsvd_b  <= st_next.rsvd_b;
      st_reg.offs_hi <= st_next.offs_hi;
      st_reg.offs_lo <= st_next.offs_lo;
      st_reg.rsvd_c  <= st_next.rsvd_c;
      st_reg.rsvd_d  <= st_next.rsvd_d;
      st_reg.rsvd_e  <= st_next.rsvd_e;
      st_reg.rsvd_f  <= st_next.rsvd_f;
      st_reg.rdata   <= st_next.rdata;
      st_reg.cal_s1  <= st_next.cal_s1;
      st_reg.cal_s2  <= st_next.cal_s2;
    end
    // only a hard reset clears the trigger bit, else the edge would loop
    if (reset) begin
      st_reg.soft_rst <= argo_pkg::RST_SOFT_RST;
    end else begin
      st_reg.soft_rst <= st_next.soft_rst;
    end
  end

  argo_srst #(
    .PULSE_CYC (SRST_PULSE)
  ) u_srst (
    .mclk      (mclk),
    .reset     (reset),
    .srst_bit  (st_reg.soft_rst[argo_pkg::SOFT_RST_BIT]),
    .dig_reset (dig_reset)
  );

  argo_offs_map u_offs (
    .mclk      (mclk),
    .reset     (any_reset),
    .code      (converter_offset_code),
    .bg_cal_en (st_reg.cal_s2),
    .offset_uv (offs_uv)
  );

  // every bank gets the same adjustment
  genvar b;
  generate
    for (b = 0; b < NUM_BANKS; b = b + 1) begin : g_bank
      assign bank_offset_uv[16*b +: 16] = offs_uv;
    end
  endgenerate

  assign full_scale_gain_code =
    {st_reg.gain_hi[argo_pkg::HI_CODE_MSB:0], st_reg.gain_lo};
  assign converter_offset_code =
    {st_reg.offs_hi[argo_pkg::HI_CODE_MSB:0], st_reg.offs_lo};
  assign digital_soft_reset = st_reg.soft_rst[argo_pkg::SOFT_RST_BIT];
  assign reg_rdata = st_reg.rdata;
  assign reg_hit   = hit;
endmodule

/* test/argo_regs_assertions.sv */
// checker for the reset, gain and offset register group
// assumes the pulse sequence check sees the default two-cycle soft reset
`timescale 1ns/1ps
module argo_chk #(
  parameter int NUM_BANKS  = 4,
  parameter int SRST_PULSE = 2
) (
  input wire logic                        mclk,
  input wire logic                        reset,
  input wire logic                        reg_wr,
  input wire logic                        reg_rd,
  input wire logic [11:0]                 reg_addr,
  input wire logic [7:0]                  reg_wdata,
  input wire logic [7:0]                  reg_rdata,
  input wire logic                        reg_hit,
  input wire logic                        bg_cal_en,
  input wire logic                        digital_soft_reset,
  input wire logic                        dig_reset,
  input wire logic [14:0]                 full_scale_gain_code,
  input wire logic [14:0]                 converter_offset_code,
  input wire logic signed [16*NUM_BANKS-1:0] bank_offset_uv
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // the repeat count is fixed to the default pulse length
  chk_srst_pulse: assert property ($rose(digital_soft_reset) |=>
    dig_reset [*2] ##1 !dig_reset) else $error("bad reset pulse");
  chk_no_selfclr: assert property (digital_soft_reset &&
    !(reg_wr && reg_addr == 12'h021) |=> digital_soft_reset)
    else $error("soft reset bit cleared");
  chk_reset_codes: assert property ($fell(dig_reset) |->
    full_scale_gain_code == 15'h4000 && converter_offset_code == 15'h4000)
    else $error("codes not at default");
  chk_gain_low: assert property (reg_wr && !dig_reset &&
    reg_addr == 12'h023 |=> full_scale_gain_code[7:0] == $past(reg_wdata))
    else $error("gain low byte lost");
  chk_offs_high: assert property (reg_wr && !dig_reset &&
    reg_addr == 12'h025 |=>
    converter_offset_code[14:8] == 7'($past(reg_wdata)))
    else $error("offset high bits lost");
  chk_bank_same: assert property (
    bank_offset_uv == {NUM_BANKS{bank_offset_uv[15:0]}})
    else $error("banks differ");
  chk_bgcal_off: assert property (bg_cal_en [*5] |->
    bank_offset_uv[15:0] == 16'h0000) else $error("offset during cal");
  chk_offs_max: assert property ((!bg_cal_en) [*5] ##0
    (converter_offset_code == 15'h7FFF) [*3] |->
    bank_offset_uv[15:0] == 16'h6D5E) else $error("bad full offset");
  // length of the current soft reset pulse, for any pulse parameter
  logic [7:0] run_q;
  always_ff @(posedge mclk) begin
    if (reset || !dig_reset) begin
      run_q <= 8'h00;
    end else begin
      run_q <= run_q + 8'h01;
    end
  end
  chk_pulse_len: assert property ($fell(dig_reset) |->
    run_q == 8'(SRST_PULSE)) else $error("reset pulse length");
endmodule
bind argo_regs argo_chk #(.NUM_BANKS(NUM_BANKS), .SRST_PULSE(SRST_PULSE))
  u_argo_chk (.mclk(mclk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_hit(reg_hit), .bg_cal_en(bg_cal_en), .dig_reset(dig_reset),
  .digital_soft_reset(digital_soft_reset),
  .full_scale_gain_code(full_scale_gain_code),
  .converter_offset_code(converter_offset_code),
  .bank_offset_uv(bank_offset_uv));

/* test/argo_host.sv */
// host model of the register port: one byte write or read per call
// assumes the device takes requests on the rising edge of mclk
`timescale 1ns/1ps
module argo_host (
  input  wire logic        mclk,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [11:0] reg_addr,
  output logic      [7:0]  reg_wdata,
  input  wire logic [7:0]  reg_rdata
);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 22'h0;
  // idle address and data lines show the inverse of the last value, never a stale copy
  task automatic op(input logic w, input logic [11:0] a,
                    input logic [7:0] v, output logic [7:0] q);
    @(posedge mclk);
    #1;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, v};
    @(posedge mclk);
    #1;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b00, ~a, ~v};
    q = reg_rdata;
  endtask
endmodule

/* test/testbench.sv */
// self-checking bench for the reset, gain and offset register group
// assumes argo_host drives the register port and argo_chk is bound
`timescale 1ns/1ps
module testbench;
  logic               mclk = 1'b0;
  logic               reset = 1'b1;
  logic               bg_cal_en = 1'b0;
  logic               reg_wr, reg_rd, reg_hit, digital_soft_reset, dig_reset;
  logic [11:0]        reg_addr;
  logic [7:0]         reg_wdata, reg_rdata, d;
  logic [14:0]        full_scale_gain_code, converter_offset_code;
  logic signed [63:0] bank_offset_uv;
  int                 n_mismatch = 0, checks = 0, n;
  // address, reset value, write data, value read back
  localparam logic [35:0] ROWS [13] = '{36'h020_9D_55_9D, 36'h021_00_FE_FE,
    36'h022_40_80_80, 36'h023_00_A5_A5, 36'h024_00_55_00, 36'h025_40_BF_BF,
    36'h026_00_3C_3C, 36'h027_06_55_06, 36'h028_BA_55_BA, 36'h029_D4_55_D4,
    36'h02A_AA_55_AA, 36'h02B_00_55_00, 36'h01F_00_55_00};
  always #20 mclk = ~mclk;
  argo_regs u_argo_regs (.mclk(mclk), .reset(reset), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_hit(reg_hit), .bg_cal_en(bg_cal_en),
    .digital_soft_reset(digital_soft_reset), .dig_reset(dig_reset),
    .full_scale_gain_code(full_scale_gain_code),
    .converter_offset_code(converter_offset_code),
    .bank_offset_uv(bank_offset_uv));
  argo_host u_argo_host (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  task automatic chk(input string nm, input logic [15:0] e, g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic stop_test;
    if (n_mismatch == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic offs(input logic [7:0] hi, lo, input logic [15:0] uv);
    u_argo_host.op(1'b1, 12'h025, hi, d);
    u_argo_host.op(1'b1, 12'h026, lo, d);
    repeat (6) @(posedge mclk);
    #1;
    for (int i = 0; i < 4; i++) chk("bank", uv, bank_offset_uv[16*i+:16]);
  endtask
  // address decode is looked at while the host still drives the address
  task automatic hit(input logic [11:0] a, input logic e);
    fork
      u_argo_host.op(1'b0, a, 8'h00, d);
      begin
        @(posedge mclk);
        #2;
        chk("reg hit", 16'(e), 16'(reg_hit));
      end
    join
  endtask
  // counts soft reset cycles after a write to the soft reset register
  task automatic srst(input logic [7:0] v, output int c);
    u_argo_host.op(1'b1, 12'h021, v, d);
    c = 0;
    repeat (8) begin
      @(posedge mclk);
      #1;
      if (dig_reset === 1'b1) c++;
    end
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    #1 reset = 1'b0;
    foreach (ROWS[k]) begin
      u_argo_host.op(1'b0, ROWS[k][35:24], 8'h00, d);
      chk("reset value", 16'(ROWS[k][23:16]), 16'(d));
      u_argo_host.op(1'b1, ROWS[k][35:24], ROWS[k][15:8], d);
      u_argo_host.op(1'b0, ROWS[k][35:24], 8'h00, d);
      chk("read back", 16'(ROWS[k][7:0]), 16'(d));
    end
    chk("gain code", 16'h00A5, 16'(full_scale_gain_code));
    chk("offset code", 16'h3F3C, 16'(converter_offset_code));
    offs(8'h00, 8'h00, 16'h92A0);
    offs(8'h60, 8'h00, 16'h36B0);
    offs(8'h40, 8'h00, 16'h0000);
    bg_cal_en = 1'b1;
    offs(8'h7F, 8'hFF, 16'h0000);
    bg_cal_en = 1'b0;
    offs(8'h7F, 8'hFF, 16'h6D5E);
    srst(8'h00, n);
    srst(8'h01, n);
    chk("reset cycles", 16'h0002, 16'(n));
    chk("gain code", 16'h4000, 16'(full_scale_gain_code));
    chk("offset code", 16'h4000, 16'(converter_offset_code));
    srst(8'h01, n);
    chk("reset cycles", 16'h0000, 16'(n));
    chk("soft bit", 16'h0001, 16'(digital_soft_reset));
    hit(12'h022, 1'b1);
    hit(12'h02A, 1'b1);
    hit(12'h02B, 1'b0);
    // hard reset in mid-run while the soft bit is still set
    reset = 1'b1;
    repeat (2) @(posedge mclk);
    #1 reset = 1'b0;
    chk("soft bit", 16'h0000, 16'(digital_soft_reset));
    chk("pulse", 16'h0000, 16'(dig_reset));
    u_argo_host.op(1'b0, 12'h021, 8'h00, d);
    chk("soft reg", 16'h0000, 16'(d));
    // a write that lands inside the soft reset pulse is lost
    u_argo_host.op(1'b1, 12'h021, 8'h00, d);
    u_argo_host.op(1'b1, 12'h021, 8'h01, d);
    u_argo_host.op(1'b1, 12'h023, 8'h77, d);
    u_argo_host.op(1'b0, 12'h023, 8'h00, d);
    chk("lost write", 16'h0000, 16'(d));
    chk("gain code", 16'h4000, 16'(full_scale_gain_code));
    stop_test;
  end
  initial begin
    #100000;
    n_mismatch++;
    stop_test;
  end
endmodule
